// >>> pkg/supply_supervisor_pkg.sv
// Constants and types for the supply supervisor logic
package supply_supervisor_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] supply_warning_control_addr = 8'hdc;
    localparam logic [7:0] supply_warning_control_rst = 8'h00;
    localparam int enable_bit = 7;
    localparam int prog_hi = 6;
    localparam int prog_lo = 5;
    localparam int warn_bit = 4;

    // ****************************************
    // Timing
    // ****************************************
    localparam int clk_period_ns = 10;
    localparam int por_hold_us = 1000;
    localparam int por_hold_cycles = (por_hold_us * 1000 + clk_period_ns - 1) / clk_period_ns;
    localparam int sync_stages = 3;

    // ****************************************
    // System modes and reset sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        mode_active = 3'h0,
        mode_standby = 3'h1,
        mode_reg_ret = 3'h2,
        mode_mem_ret = 3'h3,
        mode_deep_sleep = 3'h4
    } sys_mode_t;

    typedef enum logic [2:0] {
        st_wait_supply = 3'b001,
        st_hold = 3'b010,
        st_run = 3'b100
    } rst_state_t;
endpackage : supply_supervisor_pkg

// >>> rtl/level_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
module level_sync
    import supply_supervisor_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_async,
    output logic o_level
);
    typedef struct packed {
        logic [sync_stages-1:0] sh;
        logic level;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.sh = {state_r.sh[sync_stages-2:0], i_async};
        // Stage 0 feeds only stage 1; change taken when stages 1 and 2 agree
        if (state_r.sh[1] == state_r.sh[2]) begin
            state_nxt.level = state_r.sh[2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_level = state_r.level;
endmodule : level_sync

// >>> rtl/supply_supervisor_logic.sv
// Digital side of the power supply supervisor
// Notes on behaviour
// - After supply reaches minimum level, hold system reset at least 1 ms.
// - Brown-out indication forces system reset until it clears.
// - Precise brown-out comparator only in active/standby; low-power one otherwise.
// - Power-fail warning never resets the system.
// - Control bit 7 enables the power-fail comparator.
// - Power-fail comparator powered only in active or standby when enabled.
// - Read-only bit 4 shows supply below threshold.
// - Supply warning interrupt raised when comparator reports low supply.
// - Program memory writes blocked while warning flag is one.
// - Bits 6:5 pick 2.1/2.3/2.5/2.7 V warning threshold.
`timescale 1ns/1ps
module supply_supervisor_logic
    import supply_supervisor_pkg::*;
#(
    parameter int por_hold_count = por_hold_cycles
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_por_ok,
    input wire logic i_brownout,
    input wire logic i_pof_low,
    input wire sys_mode_t i_mode,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_prog_wr_req,
    output logic [7:0] o_sfr_rdata,
    output logic o_sys_nrst,
    output logic o_precise_bo_en,
    output logic o_lowpower_bo_en,
    output logic o_pof_en,
    output logic [1:0] o_warning_threshold_level,
    output logic o_supply_warning_irq,
    output logic o_prog_wr_en
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        rst_state_t st;
        logic [31:0] cnt;
        logic sys_nrst;
        logic enable;
        logic [1:0] prog;
        logic warn;
        logic irq;
        logic prec_en;
        logic lp_en;
        logic pof_en;
        logic wr_en;
        logic [7:0] rdata;
    } sup_state_t;

    sup_state_t state_r;
    sup_state_t state_nxt;
    logic por_ok_s;
    logic bo_s;
    logic pof_s;
    logic full_mode;

    // ****************************************
    // Input synchronisers
    // ****************************************
    level_sync u_sync_por (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(i_por_ok),
        .o_level(por_ok_s)
    );

    level_sync u_sync_bo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(i_brownout),
        .o_level(bo_s)
    );

    level_sync u_sync_pof (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(i_pof_low),
        .o_level(pof_s)
    );

    assign full_mode = (i_mode == mode_active) || (i_mode == mode_standby);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        // Reset sequencer; brown-out from any state restarts the wait
        case (state_r.st)
            st_wait_supply: begin
                state_nxt.sys_nrst = 1'b0;
                state_nxt.cnt = '0;
                if (por_ok_s && !bo_s) begin
                    state_nxt.st = st_hold;
                end
            end
            st_hold: begin
                state_nxt.sys_nrst = 1'b0;
                if (!por_ok_s || bo_s) begin
                    state_nxt.st = st_wait_supply;
                end else if (state_r.cnt >= 32'(por_hold_count - 1)) begin
                    state_nxt.st = st_run;
                    state_nxt.sys_nrst = 1'b1;
                end else begin
                    state_nxt.cnt = state_r.cnt + 32'h1;
                end
            end
            st_run: begin
                // Only supply comparators reach here; warn never does
                if (bo_s || !por_ok_s) begin
                    state_nxt.st = st_wait_supply;
                    state_nxt.sys_nrst = 1'b0;
                end
            end
            default: begin
                state_nxt.st = st_wait_supply;
                state_nxt.sys_nrst = 1'b0;
            end
        endcase

        // Brown-out comparator selection
        state_nxt.prec_en = full_mode;
        state_nxt.lp_en = !full_mode;

        // Register write; bits 3:0 and warn are not writable
        if (i_sfr_wr && i_sfr_addr == supply_warning_control_addr) begin
            state_nxt.enable = i_sfr_wdata[enable_bit];
            state_nxt.prog = i_sfr_wdata[prog_hi:prog_lo];
        end

        state_nxt.pof_en = state_nxt.enable && full_mode;
        // Comparator output meaningless while unpowered, so gate it
        state_nxt.warn = state_r.pof_en && pof_s;
        state_nxt.irq = state_nxt.warn && !state_r.warn;
        state_nxt.wr_en = i_prog_wr_req && !state_nxt.warn && !state_r.warn;

        state_nxt.rdata = 8'h00;
        if (i_sfr_rd && i_sfr_addr == supply_warning_control_addr) begin
            state_nxt.rdata[enable_bit] = state_r.enable;
            state_nxt.rdata[prog_hi:prog_lo] = state_r.prog;
            state_nxt.rdata[warn_bit] = state_r.warn;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_r <= '0;
            state_r.st <= st_wait_supply;
            state_r.prog <= supply_warning_control_rst[prog_hi:prog_lo];
            state_r.enable <= supply_warning_control_rst[enable_bit];
            state_r.lp_en <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_sfr_rdata = state_r.rdata;
    assign o_sys_nrst = state_r.sys_nrst;
    assign o_precise_bo_en = state_r.prec_en;
    assign o_lowpower_bo_en = state_r.lp_en;
    assign o_pof_en = state_r.pof_en;
    assign o_warning_threshold_level = state_r.prog;
    assign o_supply_warning_irq = state_r.irq;
    assign o_prog_wr_en = state_r.wr_en;
endmodule : supply_supervisor_logic

// >>> dv/supply_model.sv
// Behavioural model of the analog supply comparators
`timescale 1ns/1ps
module supply_model (
    input wire logic [11:0] i_vdd_mv,
    input wire logic [1:0] i_level,
    input wire logic i_en,
    output logic o_por_ok,
    output logic o_brownout,
    output logic o_pof_low
);
    // Small delay keeps edges off the clock
    assign #1 o_por_ok = i_vdd_mv >= 12'h76c;
    assign #1 o_brownout = i_vdd_mv < 12'h6a4;
    // Unpowered comparator reports no warning
    assign #1 o_pof_low = i_en && i_vdd_mv < 12'h834 + 12'hc8 * i_level;
endmodule : supply_model

// >>> dv/supply_supervisor_monitor.sv
// Assertion checker for the supply supervisor
`timescale 1ns/1ps
module supply_monitor
    import supply_supervisor_pkg::*;
#(
    parameter int por_hold_count = 20
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_por_ok,
    input wire logic i_brownout,
    input wire logic i_pof_low,
    input wire sys_mode_t i_mode,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_prog_wr_req,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_sys_nrst,
    input wire logic o_precise_bo_en,
    input wire logic o_lowpower_bo_en,
    input wire logic o_pof_en,
    input wire logic [1:0] o_warning_threshold_level,
    input wire logic o_supply_warning_irq,
    input wire logic o_prog_wr_en
);
    // ****
    // Checks
    // ****
    // Raw good-supply run length; ignores sync delay, so a lower bound only
    int cnt_r;
    always_ff @(posedge i_clk) begin
        cnt_r <= (i_nrst && i_por_ok && !i_brownout) ? cnt_r + 1 : 0;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence bo_low;
        i_brownout [*8];
    endsequence
    mode_follow_a: assert property ($past(i_nrst) |-> o_precise_bo_en == ($past(i_mode) < 3'h2))
        else $error("precise comparator enable wrong");
    bo_pair_a: assert property (o_lowpower_bo_en != o_precise_bo_en)
        else $error("comparator selects not exclusive");
    pof_power_a: assert property (o_pof_en |-> o_precise_bo_en)
        else $error("warning comparator on in low power mode");
    bo_reset_a: assert property (bo_low |=> !o_sys_nrst)
        else $error("brown-out did not reset");
    por_hold_a: assert property ($rose(o_sys_nrst) |-> cnt_r >= por_hold_count)
        else $error("reset released too early");
    irq_cause_a: assert property (o_supply_warning_irq |-> $past(o_pof_en) && !o_prog_wr_en)
        else $error("interrupt without comparator or write not blocked");
    rd_zero_a: assert property (i_sfr_rd |=> o_sfr_rdata[3:0] == 4'h0)
        else $error("unused bits read nonzero");
    rd_unmap_a: assert property (i_sfr_rd && i_sfr_addr != 8'hdc |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read nonzero");
    thr_wr_a: assert property (i_sfr_wr && i_sfr_addr == 8'hdc |=>
        o_warning_threshold_level == $past(i_sfr_wdata[6:5]))
        else $error("threshold not taken from write");
    wr_pass_a: assert property (o_prog_wr_en |-> $past(i_prog_wr_req))
        else $error("write enable without request");
endmodule : supply_monitor
bind supply_supervisor_logic supply_monitor #(.por_hold_count(por_hold_count)) u_mon (.*);

// >>> dv/supply_supervisor_logic_test.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
module supply_supervisor_logic_test;
    import supply_supervisor_pkg::*;
    logic i_clk = 0, i_nrst = 0, i_sfr_wr = 0, i_sfr_rd = 0, i_prog_wr_req = 1;
    logic [7:0] i_sfr_addr = 8'hdc, i_sfr_wdata = 8'h00, o_sfr_rdata, rd_v;
    logic [11:0] vdd = 12'h000;
    logic [1:0] o_warning_threshold_level;
    logic i_por_ok, i_brownout, i_pof_low, o_sys_nrst, o_precise_bo_en, o_lowpower_bo_en;
    logic o_pof_en, o_supply_warning_irq, o_prog_wr_en;
    sys_mode_t i_mode = mode_active;
    int n_errors = 0, num_checks = 0, irqs = 0, k;
    // Rows: threshold code [14:13], expected warn [12], supply mV [11:0]
    logic [15:0] rows [5] = '{16'h1802, 16'h38ca, 16'h5992, 16'h7a5a, 16'h6abe};
    supply_supervisor_logic #(.por_hold_count(20)) u_supply_supervisor_logic (.*);
    supply_model u_supply_model (.i_vdd_mv(vdd), .i_level(o_warning_threshold_level),
        .i_en(o_pof_en), .o_por_ok(i_por_ok), .o_brownout(i_brownout), .o_pof_low(i_pof_low));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_supply_warning_irq === 1'b1) irqs++;
    // ****
    // Tasks
    // ****
    task chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk) {i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {a, d, 1'b1};
        @(negedge i_clk) i_sfr_wr = 0;
    endtask : wr
    // Read data stands one cycle only, so it is taken at once
    task rd(input logic [7:0] a);
        @(negedge i_clk) {i_sfr_addr, i_sfr_rd} = {a, 1'b1};
        @(negedge i_clk) i_sfr_rd = 0;
        rd_v = o_sfr_rdata;
    endtask : rd
    task wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // ****
    // Sequence
    // ****
    initial begin
        repeat (20) @(negedge i_clk);
        i_nrst = 1;
        rd(8'hdc);
        chk(rd_v, 8'h00);
        chk(o_sys_nrst, 0);
        vdd = 12'hbb8;
        for (k = 0; k < 200 && o_sys_nrst !== 1'b1; k++) @(negedge i_clk);
        // Timeout counts as a mismatch as well as an early release
        chk(8'(k >= 20 && k < 200), 1);
        if (k == 200) wrap_up();
        else begin
            $display("power-on done");
            foreach (rows[i]) begin
                vdd = 12'hbb8;
                wr(8'hdc, {1'b1, rows[i][14:13], 5'h1f});
                repeat (8) @(negedge i_clk);
                vdd = rows[i][11:0];
                repeat (8) @(negedge i_clk);
                rd(8'hdc);
                chk(rd_v, {1'b1, rows[i][14:12], 4'h0});
                chk(o_prog_wr_en, !rows[i][12]);
                chk(o_sys_nrst, 1);
            end
            chk(8'(irqs), 4);
            $display("threshold table done");
            for (k = 0; k < 6; k++) begin
                @(negedge i_clk) i_mode = sys_mode_t'(k % 5);
                @(negedge i_clk);
                chk(o_pof_en, k % 5 < 2);
                chk(o_lowpower_bo_en, k % 5 > 1);
                chk(o_precise_bo_en, k % 5 < 2);
            end
            wr(8'hdd, 8'h00);
            rd(8'hdc);
            chk(rd_v, 8'he0);
            rd(8'hdd);
            chk(rd_v, 8'h00);
            wr(8'hdc, 8'h00);
            @(negedge i_clk);
            chk(o_pof_en, 0);
            chk(o_prog_wr_en, 1);
            i_prog_wr_req = 0;
            repeat (2) @(negedge i_clk);
            chk(o_prog_wr_en, 0);
            i_prog_wr_req = 1;
            vdd = 12'h640;
            repeat (10) @(negedge i_clk);
            chk(o_sys_nrst, 0);
            wr(8'hdc, 8'he0);
            i_nrst = 0;
            repeat (2) @(negedge i_clk);
            i_nrst = 1;
            rd(8'hdc);
            chk(rd_v, 8'h00);
            chk(o_sys_nrst, 0);
            $display("awkward cases done");
            wrap_up();
        end
    end
endmodule : supply_supervisor_logic_test
